/* core/hbpwm_pkg.sv */
package hbpwm_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [31:0] PAIR0_RISE_COMPARE_OFS = 32'hffff0f84;
  localparam logic [31:0] PAIR0_FALL_COMPARE_OFS = 32'hffff0f88;
  localparam logic [31:0] PAIR0_LOW_FALL_COMPARE_OFS = 32'hffff0f8c;
  localparam logic [31:0] PAIR1_RISE_COMPARE_OFS = 32'hffff0f94;
  localparam logic [31:0] PAIR1_FALL_COMPARE_OFS = 32'hffff0f98;
  localparam logic [31:0] PAIR1_LOW_FALL_COMPARE_OFS = 32'hffff0f9c;
  localparam logic [31:0] PAIR2_RISE_COMPARE_OFS = 32'hffff0fa4;
  localparam logic [31:0] PAIR2_FALL_COMPARE_OFS = 32'hffff0fa8;
  localparam logic [31:0] PAIR2_LOW_FALL_COMPARE_OFS = 32'hffff0fac;
  localparam logic [31:0] ADC_TRIGGER_CONTROL_OFS = 32'hffff0fb4;
  localparam logic [31:0] BRIDGE_CONTROL_OFS = 32'hffff0f80;
  localparam logic [31:0] TRIP_IRQ_CLEAR_OFS = 32'hffff0fb8;
  localparam logic [31:0] PAIR0_PERIOD_LENGTH_OFS = 32'hffff0f90;
  localparam logic [31:0] IRQ_STATUS_OFS = 32'hffff0fc0;
  localparam logic [31:0] IRQ_ENABLE_OFS = 32'hffff0fc4;
  localparam logic [31:0] IRQ_CLEAR_OFS = 32'hffff0fc8;
  // ==========================================================
  // Fields and reset values
  localparam logic [15:0] BRIDGE_CONTROL_RESET = 16'h0012;
  localparam logic [7:0] ADC_TRIGGER_CONTROL_RESET = 8'h00;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam int BRIDGE_ENABLE_BIT = 9;
  localparam int INVERT_ALL_BIT = 5;
  localparam int HIGH_SIDE_OFF_BIT = 4;
  localparam int SIDE_SELECT_BIT = 2;
  localparam int HBRIDGE_MODE_BIT = 1;
  localparam int TRIGGER_ENABLE_BIT = 7;
  localparam int IRQ_TRIP_BIT = 0;
  localparam int IRQ_TRIGGER_BIT = 1;
  localparam int IRQ_BITS = 2;
  // Delay is 4*(code+1) clocks, then one extra hand-over clock
  localparam logic [6:0] DELAY_STEP = 7'h04;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } hbpwm_bus_t;

  typedef struct packed {
    logic a_high;
    logic a_low;
    logic b_high;
    logic b_low;
  } hbpwm_bridge_t;

  typedef enum logic [2:0] {
    TRG_IDLE = 3'b001,
    TRG_WAIT = 3'b010,
    TRG_DONE = 3'b100
  } hbpwm_trg_state_t;
endpackage

/* core/hbpwm_top.sv */
`timescale 1ns/10ps
// Overview of operation
// RULE1: Bridge outputs from enable, off, invert, side
// RULE2: High-side-off forces 1010; disabled forces 1111
// RULE3: Waves on one pair, other held
// RULE4: Invert-all swaps side-select pair mapping
// RULE5: Bridge control resets to 0x12
// RULE6: PWM pins default to PWM function
// RULE7: Any write to clear register clears trip
// RULE8: Software clears trip before leaving handler
// RULE9: Trigger issued delay after low-side rise
// RULE10: Delay beyond pulse width gives no trigger
// RULE11: Bit 7 enables trigger; resets zero
// RULE12: Delay is four times code plus one
// RULE13: One extra clock hands trigger to ADC
// RULE14: ADC starts on next ADC clock edge
// RULE15: High wave rises at compare0, falls compare1
// RULE16: Low wave rises at period, falls compare2/high
// RULE17: Trigger is one-clock pulse per rise
// RULE18: Compare registers 16-bit RW, reset zero
module hbpwm_top #(
  parameter int TIMER_WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [TIMER_WIDTH-1:0] timer_count_i,
  input wire logic trip_i,
  output logic [31:0] rdata_o,
  output logic bridge_a_high_out_o,
  output logic bridge_a_low_out_o,
  output logic bridge_b_high_out_o,
  output logic bridge_b_low_out_o,
  output logic pwm_pin_function_o,
  output logic adc_convert_trigger_o,
  output logic irq_o
);
  // ==========================================================
  // Register storage
  hbpwm_pkg::hbpwm_bus_t bus;
  logic [15:0] bridge_control_reg;
  logic [7:0] adc_trigger_control_reg;
  logic [TIMER_WIDTH-1:0] cmp [0:8];
  logic [TIMER_WIDTH-1:0] pair0_period_length;
  logic [hbpwm_pkg::IRQ_BITS-1:0] irq_status;
  logic [hbpwm_pkg::IRQ_BITS-1:0] irq_enable;
  logic trip_meta;
  logic trip_sync;
  logic trip_prev;
  logic trip_event;
  logic trigger_event;
  logic high_side_wave;
  logic low_side_wave;
  logic low_prev;
  logic [6:0] delay_cnt;
  logic [6:0] delay_target;
  hbpwm_pkg::hbpwm_trg_state_t trg_state;
  hbpwm_pkg::hbpwm_bridge_t next_bridge;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // Index of a compare register, 4'hf when not a compare
  function automatic logic [3:0] cmp_index(input logic [31:0] a);
    unique case (a)
      hbpwm_pkg::PAIR0_RISE_COMPARE_OFS: cmp_index = 4'h0;
      hbpwm_pkg::PAIR0_FALL_COMPARE_OFS: cmp_index = 4'h1;
      hbpwm_pkg::PAIR0_LOW_FALL_COMPARE_OFS: cmp_index = 4'h2;
      hbpwm_pkg::PAIR1_RISE_COMPARE_OFS: cmp_index = 4'h3;
      hbpwm_pkg::PAIR1_FALL_COMPARE_OFS: cmp_index = 4'h4;
      hbpwm_pkg::PAIR1_LOW_FALL_COMPARE_OFS: cmp_index = 4'h5;
      hbpwm_pkg::PAIR2_RISE_COMPARE_OFS: cmp_index = 4'h6;
      hbpwm_pkg::PAIR2_FALL_COMPARE_OFS: cmp_index = 4'h7;
      hbpwm_pkg::PAIR2_LOW_FALL_COMPARE_OFS: cmp_index = 4'h8;
      default: cmp_index = 4'hf;
    endcase
  endfunction

  // ==========================================================
  // Register writes
  // RULE5: bridge control reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bridge_control_reg <= hbpwm_pkg::BRIDGE_CONTROL_RESET;
    end else if (bus.wr && bus.addr == hbpwm_pkg::BRIDGE_CONTROL_OFS) begin
      bridge_control_reg <= bus.wdata[15:0];
    end
  end

  // RULE11: trigger control register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      adc_trigger_control_reg <= hbpwm_pkg::ADC_TRIGGER_CONTROL_RESET;
    end else if (bus.wr && bus.addr == hbpwm_pkg::ADC_TRIGGER_CONTROL_OFS) begin
      adc_trigger_control_reg <= bus.wdata[7:0];
    end
  end

  // RULE18: compare registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < 9; i++) begin
        cmp[i] <= hbpwm_pkg::COMPARE_RESET;
      end
      pair0_period_length <= hbpwm_pkg::COMPARE_RESET;
    end else if (bus.wr) begin
      if (cmp_index(bus.addr) != 4'hf) begin
        cmp[cmp_index(bus.addr)] <= bus.wdata[TIMER_WIDTH-1:0];
      end
      if (bus.addr == hbpwm_pkg::PAIR0_PERIOD_LENGTH_OFS) begin
        pair0_period_length <= bus.wdata[TIMER_WIDTH-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_enable <= '0;
    end else if (bus.wr && bus.addr == hbpwm_pkg::IRQ_ENABLE_OFS) begin
      irq_enable <= bus.wdata[hbpwm_pkg::IRQ_BITS-1:0];
    end
  end

  // ==========================================================
  // Trip input and interrupts
  // Trip pin is asynchronous, so two flops before use
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      trip_meta <= 1'b1;
      trip_sync <= 1'b1;
      trip_prev <= 1'b1;
    end else begin
      trip_meta <= trip_i;
      trip_sync <= trip_meta;
      trip_prev <= trip_sync;
    end
  end

  // Trip is active low; event on falling edge
  assign trip_event = trip_prev && !trip_sync;

  // RULE7: any write clears trip, set wins
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_status <= '0;
    end else begin
      for (int i = 0; i < hbpwm_pkg::IRQ_BITS; i++) begin
        if (bus.wr && bus.addr == hbpwm_pkg::IRQ_CLEAR_OFS && bus.wdata[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
      if (bus.wr && bus.addr == hbpwm_pkg::TRIP_IRQ_CLEAR_OFS) begin
        irq_status[hbpwm_pkg::IRQ_TRIP_BIT] <= 1'b0;
      end
      if (trip_event) begin
        irq_status[hbpwm_pkg::IRQ_TRIP_BIT] <= 1'b1;
      end
      if (trigger_event) begin
        irq_status[hbpwm_pkg::IRQ_TRIGGER_BIT] <= 1'b1;
      end
    end
  end

  // RULE8: level stays until software clears
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_enable);
    end
  end

  // ==========================================================
  // Pair 0 waveforms
  // RULE15: high wave set and clear
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      high_side_wave <= 1'b0;
    end else if (timer_count_i == cmp[0]) begin
      high_side_wave <= 1'b1;
    end else if (timer_count_i == cmp[1]) begin
      high_side_wave <= 1'b0;
    end
  end

  // RULE16: low wave set and clear
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      low_side_wave <= 1'b0;
    end else if (timer_count_i == pair0_period_length) begin
      low_side_wave <= 1'b1;
    end else if (timer_count_i == cmp[2] || timer_count_i == cmp[1]) begin
      low_side_wave <= 1'b0;
    end
  end

  // ==========================================================
  // Output selection
  // RULE1: table decode
  always_comb begin
    next_bridge = '{a_high: high_side_wave, a_low: low_side_wave, b_high: high_side_wave,
                    b_low: low_side_wave};
    if (bridge_control_reg[hbpwm_pkg::HBRIDGE_MODE_BIT]) begin
      // RULE2: forced levels
      if (bridge_control_reg[hbpwm_pkg::HIGH_SIDE_OFF_BIT]) begin
        next_bridge = '{a_high: 1'b1, a_low: 1'b0, b_high: 1'b1, b_low: 1'b0};
      end else if (!bridge_control_reg[hbpwm_pkg::BRIDGE_ENABLE_BIT]) begin
        next_bridge = '{a_high: 1'b1, a_low: 1'b1, b_high: 1'b1, b_low: 1'b1};
      // RULE4: invert swaps pair choice
      end else if (bridge_control_reg[hbpwm_pkg::SIDE_SELECT_BIT] !=
                   bridge_control_reg[hbpwm_pkg::INVERT_ALL_BIT]) begin
        // RULE3: idle pair held
        next_bridge.b_high = bridge_control_reg[hbpwm_pkg::INVERT_ALL_BIT];
        next_bridge.b_low = bridge_control_reg[hbpwm_pkg::INVERT_ALL_BIT];
      end else begin
        next_bridge.a_high = bridge_control_reg[hbpwm_pkg::INVERT_ALL_BIT];
        next_bridge.a_low = bridge_control_reg[hbpwm_pkg::INVERT_ALL_BIT];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bridge_a_high_out_o <= 1'b1;
      bridge_a_low_out_o <= 1'b0;
      bridge_b_high_out_o <= 1'b1;
      bridge_b_low_out_o <= 1'b0;
    end else begin
      bridge_a_high_out_o <= next_bridge.a_high;
      bridge_a_low_out_o <= next_bridge.a_low;
      bridge_b_high_out_o <= next_bridge.b_high;
      bridge_b_low_out_o <= next_bridge.b_low;
    end
  end

  // RULE6: pins default to PWM use
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pwm_pin_function_o <= 1'b1;
    end else begin
      pwm_pin_function_o <= 1'b1;
    end
  end

  // ==========================================================
  // ADC convert trigger
  // RULE12: four clocks per code step
  assign delay_target = 7'(({3'h0, adc_trigger_control_reg[3:0]} + 7'h01) *
                        hbpwm_pkg::DELAY_STEP);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      low_prev <= 1'b0;
    end else begin
      low_prev <= low_side_wave;
    end
  end

  // RULE9: count from low-side rise
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      trg_state <= hbpwm_pkg::TRG_IDLE;
      delay_cnt <= 7'h00;
    end else begin
      unique case (trg_state)
        hbpwm_pkg::TRG_IDLE: begin
          delay_cnt <= 7'h01;
          if (low_side_wave && !low_prev &&
              adc_trigger_control_reg[hbpwm_pkg::TRIGGER_ENABLE_BIT]) begin
            trg_state <= hbpwm_pkg::TRG_WAIT;
          end
        end
        hbpwm_pkg::TRG_WAIT: begin
          delay_cnt <= 7'(delay_cnt + 7'h01);
          // RULE10: pulse ended first, abandon
          if (!low_side_wave) begin
            trg_state <= hbpwm_pkg::TRG_IDLE;
          end else if (delay_cnt == delay_target) begin
            trg_state <= hbpwm_pkg::TRG_DONE;
          end
        end
        hbpwm_pkg::TRG_DONE: begin
          // RULE17: one pulse per rise
          if (!low_side_wave) begin
            trg_state <= hbpwm_pkg::TRG_IDLE;
          end
        end
      endcase
    end
  end

  assign trigger_event = (trg_state == hbpwm_pkg::TRG_WAIT) && low_side_wave &&
                         (delay_cnt == delay_target);

  // RULE13: extra hand-over clock
  // RULE14: ADC samples this on its next edge
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      adc_convert_trigger_o <= 1'b0;
    end else begin
      adc_convert_trigger_o <= trigger_event;
    end
  end

  // ==========================================================
  // Read path, data one cycle after strobe
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (bus.rd) begin
      rdata_o <= 32'h0000_0000;
      if (cmp_index(bus.addr) != 4'hf) begin
        rdata_o[TIMER_WIDTH-1:0] <= cmp[cmp_index(bus.addr)];
      end
      unique case (bus.addr)
        hbpwm_pkg::BRIDGE_CONTROL_OFS: rdata_o[15:0] <= bridge_control_reg;
        hbpwm_pkg::ADC_TRIGGER_CONTROL_OFS: rdata_o[7:0] <= adc_trigger_control_reg;
        hbpwm_pkg::PAIR0_PERIOD_LENGTH_OFS: rdata_o[TIMER_WIDTH-1:0] <= pair0_period_length;
        hbpwm_pkg::IRQ_STATUS_OFS: rdata_o[hbpwm_pkg::IRQ_BITS-1:0] <= irq_status;
        hbpwm_pkg::IRQ_ENABLE_OFS: rdata_o[hbpwm_pkg::IRQ_BITS-1:0] <= irq_enable;
        default: ;
      endcase
    end
  end
endmodule

/* sim/hbpwm_properties.sv */
`timescale 1ns/10ps
module hbpwm_checker #(
  parameter int TIMER_WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [TIMER_WIDTH-1:0] timer_count_i,
  input wire logic trip_i,
  input wire logic [31:0] rdata_o,
  input wire logic bridge_a_high_out_o,
  input wire logic bridge_a_low_out_o,
  input wire logic bridge_b_high_out_o,
  input wire logic bridge_b_low_out_o,
  input wire logic pwm_pin_function_o,
  input wire logic adc_convert_trigger_o,
  input wire logic irq_o
);
  // ==========================================================
  // Bridge, pin, trigger, interrupt and bus checks
  wire [3:0] outs = {bridge_a_high_out_o, bridge_a_low_out_o,
    bridge_b_high_out_o, bridge_b_low_out_o};
  wire brg = wr_i && addr_i == hbpwm_pkg::BRIDGE_CONTROL_OFS;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  reset_val_a: assert property (
    $fell(reset_i) |-> outs == 4'ha) else $error("bridge reset level wrong");
  pin_func_a: assert property (
    pwm_pin_function_o) else $error("pins left PWM function");
  trig_pulse_a: assert property (
    adc_convert_trigger_o |=> !adc_convert_trigger_o) else $error("trigger too long");
  unmapped_rd_a: assert property (
    rd_i && addr_i == 32'hffff0ffc |=> rdata_o == 32'h0) else $error("unmapped read");
  disable_all_a: assert property (
    brg && wdata_i[1] && !wdata_i[4] && !wdata_i[9] ##1 !wr_i |=> outs == 4'hf)
    else $error("disabled bridge not 1111");
  high_side_off_force_a: assert property (
    brg && wdata_i[1] && wdata_i[4] ##1 !wr_i |=> outs == 4'ha)
    else $error("high-side-off not 1010");
  opp_low_a: assert property (
    brg && wdata_i[9:1] == 9'h103 ##1 !wr_i |=> outs[1:0] == 2'h0)
    else $error("idle pair not low");
  opp_high_a: assert property (
    brg && wdata_i[9:1] == 9'h113 ##1 !wr_i |=> outs[3:2] == 2'h3)
    else $error("inverted idle pair not high");
  irq_mask_a: assert property (
    wr_i && addr_i == hbpwm_pkg::IRQ_ENABLE_OFS && wdata_i[1:0] == 2'h0 ##1 !wr_i
    |=> !irq_o) else $error("masked interrupt raised");
  trip_clear_a: assert property (
    wr_i && addr_i == hbpwm_pkg::TRIP_IRQ_CLEAR_OFS ##2
    rd_i && addr_i == hbpwm_pkg::IRQ_STATUS_OFS |=> !rdata_o[0])
    else $error("trip not cleared");
  cover property (adc_convert_trigger_o);
  cover property (irq_o);
  cover property (brg && wdata_i[4]);
endmodule
bind hbpwm_top hbpwm_checker #(.TIMER_WIDTH(TIMER_WIDTH)) u_chk (.clk_i, .reset_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .timer_count_i, .trip_i, .rdata_o,
  .bridge_a_high_out_o, .bridge_a_low_out_o, .bridge_b_high_out_o,
  .bridge_b_low_out_o, .pwm_pin_function_o, .adc_convert_trigger_o, .irq_o);

/* sim/hbpwm_bridge_model.sv */
`timescale 1ns/10ps
module hbpwm_bridge_model (
  input wire logic clk_i,
  input wire logic trip_req_i,
  output logic trip_n_o
);
  // ==========================================================
  // Power stage fault line
  logic [2:0] hold = 3'h0;
  // Pulled up, so released line reads high
  assign trip_n_o = (hold == 3'h0);
  always @(posedge clk_i) begin
    if (trip_req_i) begin
      hold <= 3'h4;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
  end
endmodule

/* sim/tb.sv */
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] timer = 16'h0005;
  logic trip_req = 1'b0;
  logic trip_n;
  logic [31:0] rdata;
  logic [3:0] outs;
  logic pinf;
  logic trig;
  logic irq;
  logic [31:0] v;
  int mismatches = 0;
  int comparisons = 0;
  int trig_n = 0;
  always #12.5 clk = ~clk;
  hbpwm_top #(.TIMER_WIDTH(16)) DUT (.clk_i(clk), .reset_i(reset), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .timer_count_i(timer), .trip_i(trip_n),
    .rdata_o(rdata), .bridge_a_high_out_o(outs[3]), .bridge_a_low_out_o(outs[2]),
    .bridge_b_high_out_o(outs[1]), .bridge_b_low_out_o(outs[0]),
    .pwm_pin_function_o(pinf), .adc_convert_trigger_o(trig), .irq_o(irq));
  hbpwm_bridge_model PART (.clk_i(clk), .trip_req_i(trip_req), .trip_n_o(trip_n));
  always @(negedge clk) if (trig === 1'b1) trig_n++;
  // ==========================================================
  // Shared tasks
  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, exp, got);
    end
  endtask
  task wreg(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [31:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task tm(input logic [15:0] t);
    @(posedge clk);
    timer <= t;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [31:0] cmp(input int i);
    return 32'hffff0f84 + 32'(i / 3 * 16 + i % 3 * 4);
  endfunction
  // Row select: s = {enable, high_off, invert, side}; both waves equal w
  function automatic logic [3:0] brx(input logic [3:0] s, input logic w);
    if (s[2]) return 4'ha;
    if (!s[3]) return 4'hf;
    if (s[1] ^ s[0]) return {w, w, s[1], s[1]};
    return {s[1], s[1], w, w};
  endfunction
  // ==========================================================
  // Scenarios
  task t_reset;
    cyc(1);
    chk("outs", {28'h0, outs}, 32'ha);
    chk("pinf", {31'h0, pinf}, 32'h1);
    rreg(hbpwm_pkg::BRIDGE_CONTROL_OFS);
    chk("ctl", v, 32'h12);
    rreg(32'hffff0fb4);
    chk("adc", v, 32'h0);
    for (int i = 0; i < 9; i++) begin
      rreg(cmp(i));
      chk("cmp", v, 32'h0);
    end
    rreg(32'hffff0ffc);
    chk("unmapped", v, 32'h0);
  endtask
  task t_regs;
    for (int i = 0; i < 9; i++) wreg(cmp(i), {16'hffff, 16'(16'h1111 * (i + 1))});
    for (int i = 0; i < 9; i++) begin
      rreg(cmp(i));
      chk("cmp", v, {16'h0, 16'(16'h1111 * (i + 1))});
    end
    wreg(32'hffff0fb4, 32'h8f);
    rreg(32'hffff0fb4);
    chk("adc", v, 32'h8f);
    wreg(32'hffff0fb4, 32'h0);
  endtask
  task t_bridge;
    wreg(hbpwm_pkg::PAIR0_PERIOD_LENGTH_OFS, 32'd10);
    wreg(cmp(0), 32'd20);
    wreg(cmp(1), 32'd30);
    wreg(cmp(2), 32'd40);
    for (int w = 1; w >= 0; w--) begin
      if (w == 1) begin
        tm(16'd10);
        tm(16'd20);
        tm(16'd25);
      end else begin
        tm(16'd30);
        tm(16'd35);
      end
      for (int s = 0; s < 16; s++) begin
        wreg(hbpwm_pkg::BRIDGE_CONTROL_OFS,
          {22'h0, s[3], 3'h0, s[1], s[2], 1'b0, s[0], 2'b10});
        cyc(1);
        chk("outs", {28'h0, outs}, {28'h0, brx(s[3:0], w[0])});
      end
    end
    // Plain mode shows raw waves on both pairs
    wreg(hbpwm_pkg::BRIDGE_CONTROL_OFS, 32'h0);
    tm(16'd10);
    cyc(2);
    chk("plain_ls", {28'h0, outs}, 32'h5);
    tm(16'd20);
    cyc(2);
    chk("plain_hs", {28'h0, outs}, 32'hf);
    tm(16'd40);
    cyc(2);
    chk("plain_c2", {28'h0, outs}, 32'ha);
    tm(16'd30);
    cyc(2);
    chk("plain_off", {28'h0, outs}, 32'h0);
    chk("off_trig", 32'(trig_n), 32'h0);
  endtask
  task t_trig;
    int n;
    for (int c = 0; c < 16; c++) begin
      wreg(32'hffff0fb4, 32'h80 | 32'(c));
      tm(16'd10);
      n = 0;
      while (trig !== 1'b1 && n < 80) begin
        @(posedge clk);
        timer <= 16'd12;
        #1 n++;
      end
      chk("delay", 32'(n), 32'(4 * (c + 1) + 2));
      cyc(1);
      chk("pulse", {31'h0, trig}, 32'h0);
      tm(16'd30);
      tm(16'd35);
    end
    chk("count", 32'(trig_n), 32'd16);
    tm(16'd10);
    tm(16'd12);
    cyc(20);
    tm(16'd30);
    cyc(80);
    chk("short", 32'(trig_n), 32'd16);
    wreg(32'hffff0fb4, 32'h0);
  endtask
  task t_irq;
    int n;
    wreg(hbpwm_pkg::IRQ_ENABLE_OFS, 32'h2);
    cyc(1);
    chk("irq_trg", {31'h0, irq}, 32'h1);
    wreg(hbpwm_pkg::IRQ_CLEAR_OFS, 32'h2);
    cyc(1);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    wreg(hbpwm_pkg::IRQ_ENABLE_OFS, 32'h1);
    @(posedge clk);
    trip_req <= 1'b1;
    @(posedge clk);
    trip_req <= 1'b0;
    n = 0;
    while (irq !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    chk("irq_trip", {31'h0, irq}, 32'h1);
    rreg(hbpwm_pkg::IRQ_STATUS_OFS);
    chk("status", v & 32'h1, 32'h1);
    wreg(hbpwm_pkg::IRQ_ENABLE_OFS, 32'h0);
    cyc(1);
    chk("irq_mask", {31'h0, irq}, 32'h0);
    wreg(hbpwm_pkg::IRQ_ENABLE_OFS, 32'h1);
    cyc(1);
    chk("irq_unmask", {31'h0, irq}, 32'h1);
    wreg(hbpwm_pkg::TRIP_IRQ_CLEAR_OFS, 32'h5a5a0000);
    rreg(hbpwm_pkg::IRQ_STATUS_OFS);
    chk("trip_clr", v & 32'h1, 32'h0);
    chk("irq_off", {31'h0, irq}, 32'h0);
  endtask
  // Second reset after reconfiguration
  task t_rst2;
    wreg(hbpwm_pkg::BRIDGE_CONTROL_OFS, 32'h206);
    wreg(32'hffff0fb4, 32'h85);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    cyc(1);
    chk("outs_rst", {28'h0, outs}, 32'ha);
    rreg(hbpwm_pkg::BRIDGE_CONTROL_OFS);
    chk("ctl_rst", v, 32'h12);
    rreg(32'hffff0fb4);
    chk("adc_rst", v, 32'h0);
    chk("irq_rst", {31'h0, irq}, 32'h0);
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_regs;
    t_bridge;
    t_trig;
    t_irq;
    t_rst2;
    conclude;
  end
  // Whole run is about a thousand cycles; this is ample margin
  initial begin
    #(25 * 30000);
    mismatches++;
    conclude;
  end
endmodule
